// file: rtl/lrcc_map.svh
`ifndef LRCC_MAP_SVH
`define LRCC_MAP_SVH

// Register indices; byte address is four times the index
`define LRCC_IDX_PAR_HIGH 8'h55
`define LRCC_IDX_PAR_LOW 8'h56
`define LRCC_IDX_SELFTEST 8'h57
`define LRCC_IDX_CONFIG 8'h58
`define LRCC_IDX_RSVD_A 8'h59
`define LRCC_IDX_RSVD_B 8'h5A
`define LRCC_IDX_REMOTE_SERIALIZER_IDENTIFIER 8'h5B
`define LRCC_IDX_IRQ_STATUS 8'h70
`define LRCC_IDX_IRQ_CLEAR 8'h71
`define LRCC_IDX_IRQ_ENABLE 8'h72

// Configuration field positions
`define LRCC_CFG_PASS_ALL 7
`define LRCC_CFG_PASS_DEC 6
`define LRCC_CFG_ACK_ALL 5
`define LRCC_CFG_RL_CAM 4
`define LRCC_CFG_CRC_ON 3
`define LRCC_CFG_RATE_HI 1
`define LRCC_CFG_RATE_LO 0

// Identifier register field positions
`define LRCC_ID_HI 7
`define LRCC_ID_LO 1
`define LRCC_ID_HOLD 0

// Interrupt status bit positions
`define LRCC_IRQ_PARITY 0
`define LRCC_IRQ_SELFTEST 1
`define LRCC_IRQ_ID_LOAD 2

// Reset values
`define LRCC_RST_CONFIG 8'h18
`define LRCC_RST_REMOTE_SERIALIZER_IDENTIFIER 7'h00
`define LRCC_RST_COUNT 16'h0000
`define LRCC_RST_IRQ 3'h0

// Return link rate codes
`define LRCC_RATE_FAST 2'h0
`define LRCC_RATE_SLOW 2'h1

`endif

// file: rtl/lrcc_pkg.sv
package lrcc_pkg;

	// Bus slave phase, one-hot
	typedef enum logic [3:0] {
		LRCC_IDLE = 4'h1,
		LRCC_RD_WAIT = 4'h2,
		LRCC_RD_DONE = 4'h4,
		LRCC_WR_DATA = 4'h8
	} lrcc_bus_e;

	// Local I2C transaction offered for forwarding
	typedef struct packed {
		logic start;
		logic addr_match;
		logic is_write;
	} lrcc_i2c_req_s;

	// Settings driven into the return link
	typedef struct packed {
		logic link_on;
		logic crc_on;
		logic [1:0] rate_code;
	} lrcc_link_cfg_s;

	// Whole block state
	typedef struct packed {
		lrcc_bus_e bus;
		logic [7:0] idx;
		logic [31:0] rdata;
		logic [15:0] par_cnt;
		logic [7:0] st_cnt;
		logic pass_all;
		logic pass_dec;
		logic ack_all;
		logic rl_cam;
		logic crc_on;
		logic [1:0] rate;
		logic [6:0] remote_serializer_identifier;
		logic hold;
		logic [2:0] irq_status;
		logic [2:0] irq_enable;
		logic forward;
		logic ack;
		lrcc_link_cfg_s link;
	} lrcc_state_s;

endpackage : lrcc_pkg

// file: rtl/lrcc_regs.sv
// Overview of operation
// - Receiver parity errors are counted, restarting on valid lock or a low-byte read, low 8 bits in the low register.
// - Any read of the low count register clears the count.
// - The upper 8 count bits sit in the high register and clear when the low register is read.
// - The self-test error count is a read-only 8-bit register.
// - With pass-all set, every local I2C transaction is forwarded to the serializer.
// - With decoded pass-through set and pass-all clear, a transaction is forwarded only on an address match.
// - With acknowledge-all set, all I2C writes are acknowledged locally whatever the lock or remote answer.
// - In camera mode the return link runs only while its enable bit is set; in display mode always.
// - The return link CRC generator runs while its bit is set.
// - The 2-bit rate field picks the return link rate: 00 fast, 01 slow, others reserved.
// - The serializer identifier loads from the remote side but software may still write it.
// - While hold is set the identifier stops auto-loading and keeps the written value.
`include "lrcc_map.svh"

module lrcc_regs
	import lrcc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_parity_error,
	input wire logic i_lock_detect,
	input wire logic i_fwd_locked,
	input wire logic i_selftest_error,
	input wire logic i_id_valid,
	input wire logic [6:0] i_id_value,
	input wire logic i_camera_mode,
	input wire lrcc_i2c_req_s i_i2c_req,
	input wire logic i_remote_ack,
	output logic o_i2c_forward,
	output logic o_i2c_ack,
	output lrcc_link_cfg_s o_link_cfg,
	output logic [6:0] o_remote_serializer_identifier,
	output logic o_irq
);

	// Whole block state and its next value
	lrcc_state_s state;
	lrcc_state_s next_state;

	// Configuration byte after reset; all fields but the rate are picked from it by position
	localparam logic [7:0] cfg_reset = `LRCC_RST_CONFIG;

	// Word index of a byte address, or all ones when misaligned or out of range
	// All ones decodes to no register, so stray addresses read zero and write nothing
	function automatic logic [7:0] lrcc_index(input logic [31:0] addr);
		logic [7:0] idx;
		// Aligned words inside the window map one to one onto indices
		idx = addr[9:2];
		if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0)
		begin
			idx = 8'hFF;
		end
		return idx;
	endfunction : lrcc_index

	// Register read value for a word index
	// Pure decode; the clear-on-read side effect lives in the bus sequencer
	function automatic logic [7:0] lrcc_read(input lrcc_state_s s, input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx == `LRCC_IDX_PAR_HIGH)
		begin
			v = s.par_cnt[15:8];
		end
		else if (idx == `LRCC_IDX_PAR_LOW)
		begin
			v = s.par_cnt[7:0];
		end
		else if (idx == `LRCC_IDX_SELFTEST)
		begin
			v = s.st_cnt;
		end
		else if (idx == `LRCC_IDX_CONFIG)
		begin
			// Bit 2 is reserved and stays zero
			v[`LRCC_CFG_PASS_ALL] = s.pass_all;
			v[`LRCC_CFG_PASS_DEC] = s.pass_dec;
			v[`LRCC_CFG_ACK_ALL] = s.ack_all;
			v[`LRCC_CFG_RL_CAM] = s.rl_cam;
			v[`LRCC_CFG_CRC_ON] = s.crc_on;
			v[`LRCC_CFG_RATE_HI:`LRCC_CFG_RATE_LO] = s.rate;
		end
		else if (idx == `LRCC_IDX_REMOTE_SERIALIZER_IDENTIFIER)
		begin
			// Identifier sits above the hold bit
			v[`LRCC_ID_HI:`LRCC_ID_LO] = s.remote_serializer_identifier;
			v[`LRCC_ID_HOLD] = s.hold;
		end
		else if (idx == `LRCC_IDX_IRQ_STATUS)
		begin
			v = {5'h00, s.irq_status};
		end
		else if (idx == `LRCC_IDX_IRQ_ENABLE)
		begin
			v = {5'h00, s.irq_enable};
		end
		else
		begin
			v = 8'h00;
		end
		return v;
	endfunction : lrcc_read

	// Bus strobe, write byte, event vector and identifier load
	logic accept;
	logic [7:0] wdata;
	logic [2:0] events;
	logic id_load;

	// Address phase accepted only when the bus is ready
	assign accept = i_hsel && i_htrans[1] && i_hready;

	// Only the low byte of the write word carries register bits
	assign wdata = i_hwdata[7:0];

	// Remote identifier frames are dropped while software holds the value
	assign id_load = i_id_valid && !state.hold;

	// Hardware events feeding the sticky status
	// One status bit per event, positions from the map
	always_comb
	begin
		events = 3'h0;
		events[`LRCC_IRQ_PARITY] = i_parity_error;
		events[`LRCC_IRQ_SELFTEST] = i_selftest_error;
		events[`LRCC_IRQ_ID_LOAD] = id_load;
	end

	// Next state of the whole block
	always_comb
	begin
		next_state = state;

		// Counters run every cycle
		// A valid lock restarts the parity count from zero
		if (i_lock_detect)
		begin
			next_state.par_cnt = `LRCC_RST_COUNT;
		end
		// Self-test errors saturate so a long burst never reads back small
		if (i_selftest_error && state.st_cnt != 8'hFF)
		begin
			next_state.st_cnt = state.st_cnt + 8'h01;
		end

		// Remote identifier auto-load
		if (id_load)
		begin
			next_state.remote_serializer_identifier = i_id_value;
		end

		// Bus phase sequencing
		// A read spends one wait cycle here so the register is sampled into the
		// read data flop; a low count read clears both count bytes in that cycle.
		// A write lands at the end of its data phase and adds no wait state.
		case (state.bus)
			LRCC_RD_WAIT:
			begin
				// Upper read data bits are always zero
				next_state.rdata = {24'h000000, lrcc_read(state, state.idx)};
				if (state.idx == `LRCC_IDX_PAR_LOW)
				begin
					next_state.par_cnt = `LRCC_RST_COUNT;
				end
				next_state.bus = LRCC_RD_DONE;
			end
			LRCC_WR_DATA:
			begin
				if (state.idx == `LRCC_IDX_CONFIG)
				begin
					// Reserved bit 2 is dropped so it always reads zero
					next_state.pass_all = wdata[`LRCC_CFG_PASS_ALL];
					next_state.pass_dec = wdata[`LRCC_CFG_PASS_DEC];
					next_state.ack_all = wdata[`LRCC_CFG_ACK_ALL];
					next_state.rl_cam = wdata[`LRCC_CFG_RL_CAM];
					next_state.crc_on = wdata[`LRCC_CFG_CRC_ON];
					next_state.rate = wdata[`LRCC_CFG_RATE_HI:`LRCC_CFG_RATE_LO];
				end
				else if (state.idx == `LRCC_IDX_REMOTE_SERIALIZER_IDENTIFIER)
				begin
					// Software write wins over an auto-load in the same cycle
					next_state.remote_serializer_identifier = wdata[`LRCC_ID_HI:`LRCC_ID_LO];
					next_state.hold = wdata[`LRCC_ID_HOLD];
				end
				else if (state.idx == `LRCC_IDX_IRQ_CLEAR)
				begin
					// Ones clear status bits, zeros leave them
					next_state.irq_status = state.irq_status & ~wdata[2:0];
				end
				else if (state.idx == `LRCC_IDX_IRQ_ENABLE)
				begin
					// Enable bits use the status layout
					next_state.irq_enable = wdata[2:0];
				end
				next_state.bus = LRCC_IDLE;
			end
			default:
			begin
				next_state.bus = LRCC_IDLE;
			end
		endcase

		// New address phase
		// Only taken while ready, so it never lands on a read wait cycle
		if (accept)
		begin
			next_state.idx = lrcc_index(i_haddr);
			next_state.bus = i_hwrite ? LRCC_WR_DATA : LRCC_RD_WAIT;
		end

		// Parity count, an error in the clearing cycle still counts
		// Saturates at all ones instead of wrapping back to zero
		if (i_parity_error && next_state.par_cnt != 16'hFFFF)
		begin
			next_state.par_cnt = next_state.par_cnt + 16'h0001;
		end

		// Sticky status, set wins over clear
		// An event in the cycle of a clear write leaves its bit set
		next_state.irq_status = next_state.irq_status | events;

		// I2C forwarding decision per transaction
		// Decided once at the start and held until the next transaction
		if (i_i2c_req.start)
		begin
			next_state.forward = state.pass_all
				|| (state.pass_dec && i_i2c_req.addr_match);
		end

		// Local acknowledge
		// The remote answer only counts while the forward link is locked
		next_state.ack = (state.ack_all && i_i2c_req.is_write)
			|| (i_fwd_locked && i_remote_ack);

		// Return link settings
		// Display mode keeps the return link on whatever the camera bit says
		// Reserved rate codes are passed on unchanged
		next_state.link.link_on = !i_camera_mode || state.rl_cam;
		next_state.link.crc_on = state.crc_on;
		next_state.link.rate_code = state.rate;
	end

	// State register
	// Reset loads the defaults; the bus starts idle and ready
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state.bus <= LRCC_IDLE;
			state.idx <= 8'h00;
			state.rdata <= 32'h00000000;
			state.par_cnt <= `LRCC_RST_COUNT;
			state.st_cnt <= 8'h00;
			state.pass_all <= cfg_reset[`LRCC_CFG_PASS_ALL];
			state.pass_dec <= cfg_reset[`LRCC_CFG_PASS_DEC];
			state.ack_all <= cfg_reset[`LRCC_CFG_ACK_ALL];
			state.rl_cam <= cfg_reset[`LRCC_CFG_RL_CAM];
			state.crc_on <= cfg_reset[`LRCC_CFG_CRC_ON];
			state.rate <= `LRCC_RATE_FAST;
			state.remote_serializer_identifier <= `LRCC_RST_REMOTE_SERIALIZER_IDENTIFIER;
			state.hold <= 1'b0;
			state.irq_status <= `LRCC_RST_IRQ;
			state.irq_enable <= `LRCC_RST_IRQ;
			state.forward <= 1'b0;
			state.ack <= 1'b0;
			state.link.link_on <= cfg_reset[`LRCC_CFG_RL_CAM];
			state.link.crc_on <= cfg_reset[`LRCC_CFG_CRC_ON];
			state.link.rate_code <= `LRCC_RATE_FAST;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Bus answer, one wait state on reads
	// Response is always OKAY; nothing on this bus is refused
	assign o_hrdata = state.rdata;
	assign o_hreadyout = (state.bus != LRCC_RD_WAIT);
	assign o_hresp = 1'b0;

	// Block outputs
	// Interrupt is a level, high while any enabled status bit is set
	assign o_i2c_forward = state.forward;
	assign o_i2c_ack = state.ack;
	assign o_link_cfg = state.link;
	assign o_remote_serializer_identifier = state.remote_serializer_identifier;
	assign o_irq = |(state.irq_status & state.irq_enable);

endmodule : lrcc_regs

// file: sim/lrcc_regs_checker.sv
module lrcc_regs_checker
	import lrcc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_hsel,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic i_fwd_locked,
	input wire logic i_remote_ack,
	input wire logic i_camera_mode,
	input wire lrcc_i2c_req_s i_i2c_req,
	input wire logic o_i2c_forward,
	input wire logic o_i2c_ack,
	input wire lrcc_link_cfg_s o_link_cfg
);
	timeunit 1ns;
	timeprecision 1ns;
	logic wr_dp;
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	// Marks the data phase of a write, when settings may change
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			wr_dp <= 1'b0;
		else
			wr_dp <= i_hsel & i_htrans[1] & i_hready & i_hwrite;
	end
	property p_resp; o_hresp == 1'b0; endproperty
	a_resp: assert property (p_resp) else $error("response not OKAY");
	property p_rd_wait; i_hsel && i_htrans[1] && i_hready && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_zero; i_hsel && i_htrans[1] && i_hready && i_hwrite |=> o_hreadyout; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
	property p_fwd_hold; !i_i2c_req.start |=> $stable(o_i2c_forward); endproperty
	a_fwd_hold: assert property (p_fwd_hold) else $error("forward changed without start");
	property p_ack_remote; i_fwd_locked && i_remote_ack |=> o_i2c_ack; endproperty
	a_ack_remote: assert property (p_ack_remote) else $error("remote acknowledge lost");
	property p_disp_link; !i_camera_mode ##1 !i_camera_mode |-> o_link_cfg.link_on; endproperty
	a_disp_link: assert property (p_disp_link) else $error("link off in display mode");
	property p_cfg_hold; !$past(wr_dp) && !$past(wr_dp, 2) |-> $stable({o_link_cfg.crc_on, o_link_cfg.rate_code}); endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("link setting changed unwritten");
	property p_rdata_hi; o_hrdata[31:8] == 24'h000000; endproperty
	a_rdata_hi: assert property (p_rdata_hi) else $error("upper read data not zero");
endmodule : lrcc_regs_checker

bind lrcc_regs lrcc_regs_checker u_checker (.*);

// file: sim/lrcc_serializer_model.sv
module lrcc_serializer_model
(
	input wire logic i_ref_clk,
	input wire logic i_send,
	input wire logic [6:0] i_id,
	input wire logic i_ack,
	output logic o_id_valid = 1'b0,
	output logic [6:0] o_id_value = 7'h55,
	output logic o_remote_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	// Identifier frame; value lines toggle between frames so stale data never looks valid
	always @(posedge i_ref_clk)
	begin
		o_id_valid <= i_send;
		o_id_value <= i_send ? i_id : ~o_id_value;
	end
	// Acknowledge as the bench commands
	assign o_remote_ack = i_ack;
endmodule : lrcc_serializer_model

// file: sim/tb_lrcc_regs.sv
`include "lrcc_map.svh"
module tb_lrcc_regs
	import lrcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
	logic i_parity_error = 1'b0, i_lock_detect = 1'b0, i_selftest_error = 1'b0;
	logic i_fwd_locked = 1'b0, i_camera_mode = 1'b0, send = 1'b0, rack = 1'b0;
	logic [1:0] i_htrans = 2'h0;
	logic [2:0] i_hsize = 3'h2;
	logic [6:0] sid = 7'h00;
	logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0;
	lrcc_i2c_req_s i_i2c_req = '0;
	logic [15:0] lf = 16'h2BE1;
	logic [31:0] o_hrdata;
	logic o_hreadyout, o_hresp, o_i2c_forward, o_i2c_ack, o_irq, i_id_valid, i_remote_ack;
	logic [6:0] i_id_value, o_remote_serializer_identifier;
	lrcc_link_cfg_s o_link_cfg;
	logic [7:0] v;
	int miscompares = 0, compares = 0;

	lrcc_regs dut (.i_hready(o_hreadyout), .*);
	lrcc_serializer_model m_ser (.i_ref_clk, .i_send(send), .i_id(sid), .i_ack(rack),
		.o_id_valid(i_id_valid), .o_id_value(i_id_value), .o_remote_ack(i_remote_ack));

	// Free-running clock
	initial
	begin
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx

	function automatic lrcc_link_cfg_s exp_link(input logic m, input logic [7:0] c);
		return {m ? c[4] : 1'b1, c[3], c[1:0]};
	endfunction : exp_link

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// One AHB-Lite word transfer, held until ready at each phase
	task automatic xfer(input logic w, input logic [7:0] ix, input logic [7:0] d,
		output logic [31:0] q);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_hwrite <= w;
		i_haddr <= {22'h0, ix, 2'h0};
		@(posedge i_ref_clk);
		while (o_hreadyout !== 1'b1)
			@(posedge i_ref_clk);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= {24'h0, d};
		@(posedge i_ref_clk);
		while (o_hreadyout !== 1'b1)
			@(posedge i_ref_clk);
		q = o_hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, ix, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] ix, input logic [7:0] e);
		logic [31:0] q;
		xfer(1'b0, ix, 8'h00, q);
		chk(q, {24'h0, e});
	endtask : rd

	// Event pulses: bit0 parity, bit1 lock, bit2 self-test
	task automatic pulse(input logic [2:0] m, input int n);
		repeat (n)
		begin
			{i_selftest_error, i_lock_detect, i_parity_error} <= m;
			@(posedge i_ref_clk);
		end
		{i_selftest_error, i_lock_detect, i_parity_error} <= 3'h0;
		@(posedge i_ref_clk);
	endtask : pulse

	task automatic id_send(input logic [6:0] s);
		sid <= s;
		send <= 1'b1;
		@(posedge i_ref_clk);
		send <= 1'b0;
		repeat (2)
			@(posedge i_ref_clk);
	endtask : id_send

	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial
	begin
		repeat (6)
			@(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		@(posedge i_ref_clk);
		rd(`LRCC_IDX_CONFIG, `LRCC_RST_CONFIG);
		for (int i = 8'h55; i < 8'h5C; i++)
			if (i != 8'h58)
				rd(i[7:0], 8'h00);
		rd(8'h40, 8'h00);
		pulse(3'h1, 300);
		rd(`LRCC_IDX_PAR_HIGH, 8'h01);
		rd(`LRCC_IDX_PAR_LOW, 8'h2C);
		rd(`LRCC_IDX_PAR_HIGH, 8'h00);
		rd(`LRCC_IDX_PAR_LOW, 8'h00);
		lf = nx(lf);
		pulse(3'h1, 1 + lf[4:0]);
		rd(`LRCC_IDX_PAR_LOW, 8'h01 + lf[4:0]);
		pulse(3'h1, 5);
		pulse(3'h2, 1);
		rd(`LRCC_IDX_PAR_LOW, 8'h00);
		pulse(3'h4, 7);
		wr(`LRCC_IDX_SELFTEST, 8'hFF);
		rd(`LRCC_IDX_SELFTEST, 8'h07);
		pulse(3'h4, 250);
		rd(`LRCC_IDX_SELFTEST, 8'hFF);
		// Interrupt status starts clean so each event is seen on its own
		wr(`LRCC_IDX_IRQ_CLEAR, 8'h07);
		rd(`LRCC_IDX_IRQ_STATUS, 8'h00);
		wr(`LRCC_IDX_IRQ_ENABLE, 8'h01);
		rd(`LRCC_IDX_IRQ_ENABLE, 8'h01);
		chk({31'h0, o_irq}, 32'h0);
		pulse(3'h1, 1);
		chk({31'h0, o_irq}, 32'h1);
		pulse(3'h4, 1);
		rd(`LRCC_IDX_IRQ_STATUS, 8'h03);
		wr(`LRCC_IDX_IRQ_CLEAR, 8'h01);
		@(posedge i_ref_clk);
		chk({31'h0, o_irq}, 32'h0);
		rd(`LRCC_IDX_IRQ_STATUS, 8'h02);
		// Every pass-through combination and every rate code, auto-acknowledge kept on
		for (int i = 0; i < 8; i++)
		begin
			lf = nx(lf);
			v = {i[1:0], 1'b1, lf[2:0], i[2:1]};
			i_camera_mode <= i[2];
			wr(`LRCC_IDX_CONFIG, v);
			i_i2c_req <= '{1'b1, i[2], 1'b0};
			@(posedge i_ref_clk);
			i_i2c_req <= '0;
			@(posedge i_ref_clk);
			chk({31'h0, o_i2c_forward}, {31'h0, v[7] | (v[6] & i[2])});
			chk({28'h0, o_link_cfg}, {28'h0, exp_link(i[2], v)});
			rd(`LRCC_IDX_CONFIG, v & 8'hFB);
		end
		wr(`LRCC_IDX_CONFIG, 8'h20);
		i_i2c_req <= '{1'b0, 1'b0, 1'b1};
		repeat (2)
			@(posedge i_ref_clk);
		chk({31'h0, o_i2c_ack}, 32'h1);
		i_i2c_req <= '0;
		i_fwd_locked <= 1'b1;
		rack <= 1'b1;
		repeat (2)
			@(posedge i_ref_clk);
		chk({31'h0, o_i2c_ack}, 32'h1);
		rack <= 1'b0;
		repeat (2)
			@(posedge i_ref_clk);
		chk({31'h0, o_i2c_ack}, 32'h0);
		lf = nx(lf);
		id_send(lf[6:0]);
		rd(`LRCC_IDX_REMOTE_SERIALIZER_IDENTIFIER, {lf[6:0], 1'b0});
		rd(`LRCC_IDX_IRQ_STATUS, 8'h06);
		wr(`LRCC_IDX_IRQ_CLEAR, 8'h04);
		wr(`LRCC_IDX_REMOTE_SERIALIZER_IDENTIFIER, 8'h55);
		id_send(~lf[6:0]);
		rd(`LRCC_IDX_REMOTE_SERIALIZER_IDENTIFIER, 8'h55);
		rd(`LRCC_IDX_IRQ_STATUS, 8'h02);
		chk({25'h0, o_remote_serializer_identifier}, 32'h2A);
		report_and_stop();
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#400000;
		miscompares++;
		report_and_stop();
	end
endmodule : tb_lrcc_regs
